// ===== design/e2p_cfg.svh
/*
  constants of the serial memory controller: pin-level opcodes, host
  operation codes, frame lengths and timing counts.
  assumes a 250 MHz system clock and a byte-organised three-wire memory.
*/
`ifndef E2P_CFG_SVH
`define E2P_CFG_SVH

// ---------------------------------------------------------------
// host operation codes (operation_code_field)
// ---------------------------------------------------------------
`define OP_READ 3'h0
`define OP_WDIS 3'h1
`define OP_WEN 3'h2
`define OP_WRITE 3'h3
`define OP_WALL 3'h4
`define OP_ERASE 3'h5
`define OP_EALL 3'h6
`define OP_RELOAD 3'h7

// ---------------------------------------------------------------
// pin-level opcodes and location prefixes
// ---------------------------------------------------------------
`define SER_START 1'h1
`define SER_READ 2'h2
`define SER_WRITE 2'h1
`define SER_ERASE 2'h3
`define SER_CTRL 2'h0
`define LOC_WEN 7'h60
`define LOC_WDIS 7'h00
`define LOC_EALL 7'h40
`define LOC_WALL 7'h20

// ---------------------------------------------------------------
// frame shape and autoload
// ---------------------------------------------------------------
`define BITS_SHORT 5'h0a
`define BITS_LONG 5'h12
`define SIG_BYTE 8'ha5
`define ADDR_BYTES 3'h6
`define LOC_W 7
`define DATA_W 8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_NS 4
`define SCLK_HALF_NS 500
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_NS - 1) / `CLK_NS)
`define CS_GAP_NS 500
`define CS_GAP_CYC ((`CS_GAP_NS + `CLK_NS - 1) / `CLK_NS)
`define POLL_SETTLE_NS 500
`define POLL_SETTLE_CYC ((`POLL_SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define RESP_TIMEOUT_MS 30
`define RESP_TIMEOUT_CYC (`RESP_TIMEOUT_MS * 1000000 / `CLK_NS)

`endif

// ===== design/e2p_pkg.sv
/*
  types shared by the serial memory controller, its checker and its bench.
  assumes e2p_cfg.svh is compiled alongside.
*/
package e2p_pkg;

  // controller sequencing states
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP, ST_POLL} ctl_state_t;

  // memory_command_reg contents written by the host
  typedef struct packed {
    logic [2:0] operation_code_field;
    logic [6:0] location_field;
  } cmd_t;

  // status bits of memory_command_reg
  typedef struct packed {
    logic operation_busy_flag;
    logic response_timeout_flag;
    logic address_loaded_flag;
    logic reload_done_flag;
  } flags_t;

endpackage : e2p_pkg

// ===== design/bit_sync.sv
/*
  two-flop synchroniser for levels from outside the clock domain.
  assumes the input is a level that holds for several clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // levels
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);

  logic [W-1:0] meta; // first stage, read by q only

  // --------------------------------------------------------------
  // two stages
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : bit_sync
`default_nettype wire

// ===== design/serial_shifter.sv
/*
  serial frame engine: divides the system clock into the serial clock,
  shifts a frame out MSB first and samples the data pin on rising edges.
  assumes the caller holds nbits, drive and tx steady while busy.
*/
`timescale 1ns/1ns
`default_nettype none
`include "e2p_cfg.svh"
module serial_shifter #(
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // frame request
  input wire logic start,
  input wire logic [4:0] nbits,
  input wire logic [4:0] drive,
  input wire logic [17:0] tx,
  // frame result
  output var logic done,
  output var logic [7:0] rx,
  // serial lines
  input wire logic sdi,
  output var logic sclk,
  output var logic sdo,
  output var logic sdo_oe
);

  localparam int DW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

  logic active, next_active; // frame in flight
  logic [DW-1:0] div, next_div; // half-period counter
  logic [4:0] cnt, next_cnt; // bits completed
  logic [17:0] sh, next_sh; // outgoing bits, MSB at top
  logic next_sclk;
  logic [7:0] next_rx;
  logic next_done;

  // --------------------------------------------------------------
  // next state: data changes while clock is low, sampled on rise
  // --------------------------------------------------------------
  always_comb begin
    next_active = active;
    next_div = div;
    next_cnt = cnt;
    next_sh = sh;
    next_sclk = sclk;
    next_rx = rx;
    next_done = 1'b0;
    if (!active) begin
      if (start) begin // load a fresh frame
        next_active = 1'b1;
        next_sh = tx;
        next_cnt = 5'h00;
        next_div = '0;
        next_sclk = 1'b0;
      end
    end else if (div == DW'(HALF_CYC - 1)) begin
      next_div = '0;
      if (!sclk) begin // rising edge: memory output is valid
        next_sclk = 1'b1;
        next_rx = {rx[6:0], sdi};
      end else begin // falling edge: present the next bit
        next_sclk = 1'b0;
        next_cnt = 5'(cnt + 5'h01);
        next_sh = {sh[16:0], 1'b0};
        if (5'(cnt + 5'h01) == nbits) begin
          next_active = 1'b0;
          next_done = 1'b1;
        end
      end
    end else begin
      next_div = DW'(div + 1'b1);
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      active <= 1'b0;
      div <= '0;
      cnt <= 5'h00;
      sh <= 18'h00000;
      sclk <= 1'b0;
      rx <= 8'h00;
      done <= 1'b0;
    end else begin
      active <= next_active;
      div <= next_div;
      cnt <= next_cnt;
      sh <= next_sh;
      sclk <= next_sclk;
      rx <= next_rx;
      done <= next_done;
    end
  end

  // line outputs follow the registers; the top registers them again
  assign sdo = sh[17];
  assign sdo_oe = active && (cnt < drive); // release for read data

endmodule : serial_shifter
`default_nettype wire

// ===== design/e2p_ctrl.sv
/*
  serial memory controller: boot-time station address load, host
  operations through command/data ports, write completion polling with
  timeout, and pin reuse when the interface is disabled.
  assumes host ports come from logic on clk_sys; serial_data_in is a pin.
*/
`timescale 1ns/1ns
`default_nettype none
`include "e2p_cfg.svh"
module e2p_ctrl
  import e2p_pkg::*;
#(
  parameter int TIMEOUT_CYC = `RESP_TIMEOUT_CYC,
  parameter int HALF_CYC = `SCLK_HALF_CYC
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic soft_rst,
  // host command and data writes
  input wire logic cmd_write,
  input wire cmd_t cmd_in,
  input wire logic cmd_busy_set,
  input wire logic data_write,
  input wire logic [7:0] data_in,
  // host readback
  output var cmd_t memory_command_reg,
  output var flags_t status,
  output var logic [7:0] memory_data_reg,
  output var logic [31:0] station_address_low,
  output var logic [15:0] station_address_high,
  // pin configuration
  input wire logic iface_disable,
  input wire logic pin_mon_sel,
  input wire logic [1:0] gp_out,
  input wire logic [1:0] mii_mon,
  // serial memory pins
  output var logic serial_chip_select,
  output var logic serial_clock_pin,
  output var logic serial_data_out,
  output var logic serial_data_oe,
  input wire logic serial_data_in
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  ctl_state_t state, next_state; // sequencer
  logic [CW-1:0] cnt, next_cnt; // gap, settle and timeout counter
  logic loading, next_loading; // address load in progress
  logic reload, next_reload; // load was host requested
  logic poll, next_poll; // ready poll owed after gap
  logic [2:0] idx, next_idx; // next autoload location
  logic [2:0] op, next_op; // operation on the wire
  logic [6:0] loc, next_loc; // location on the wire
  logic cs, next_cs; // chip select
  logic start, next_start; // shifter kick
  logic [47:0] station, next_station; // byte 0 in the low bits
  cmd_t next_cmd;
  flags_t next_status;
  logic [7:0] next_data;

  // shifter and pin wires
  logic din_s; // synchronised data pin
  logic sh_done;
  logic [7:0] sh_rx;
  logic sh_sclk;
  logic sh_sdo;
  logic sh_oe;
  logic [4:0] nbits;
  logic [4:0] drive;
  logic [17:0] tx;
  logic [2:0] idx_m1;

  // --------------------------------------------------------------
  // frame builder
  // --------------------------------------------------------------
  // opcode and location prefix per host operation
  always_comb begin
    tx = 18'h00000;
    nbits = `BITS_SHORT;
    drive = `BITS_SHORT;
    case (op)
      `OP_READ, `OP_RELOAD: begin
        tx = {`SER_START, `SER_READ, loc, 8'h00};
        nbits = `BITS_LONG;
      end
      `OP_WRITE: begin
        tx = {`SER_START, `SER_WRITE, loc, memory_data_reg};
        nbits = `BITS_LONG;
        drive = `BITS_LONG;
      end
      `OP_WALL: begin
        tx = {`SER_START, `SER_CTRL, `LOC_WALL, memory_data_reg};
        nbits = `BITS_LONG;
        drive = `BITS_LONG;
      end
      `OP_ERASE: tx = {`SER_START, `SER_ERASE, loc, 8'h00};
      `OP_EALL: tx = {`SER_START, `SER_CTRL, `LOC_EALL, 8'h00};
      `OP_WEN: tx = {`SER_START, `SER_CTRL, `LOC_WEN, 8'h00};
      default: tx = {`SER_START, `SER_CTRL, `LOC_WDIS, 8'h00};
    endcase
  end

  assign idx_m1 = 3'(idx - 3'h1);

  // --------------------------------------------------------------
  // sequencer next state
  // --------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_loading = loading;
    next_reload = reload;
    next_poll = poll;
    next_idx = idx;
    next_op = op;
    next_loc = loc;
    next_cs = cs;
    next_start = 1'b0;
    next_station = station;
    next_cmd = memory_command_reg;
    next_status = status;
    next_data = memory_data_reg;
    case (state)
      // host may write only while idle; busy writes are ignored
      ST_IDLE: begin
        if (data_write) begin
          next_data = data_in;
        end
        if (cmd_write) begin
          next_cmd = cmd_in;
          if (cmd_busy_set) begin
            next_status.operation_busy_flag = 1'b1;
            next_status.response_timeout_flag = 1'b0;
            if (cmd_in.operation_code_field == `OP_RELOAD) begin
              next_loading = 1'b1;
              next_reload = 1'b1;
              next_idx = 3'h0;
              next_status.address_loaded_flag = 1'b0;
              next_status.reload_done_flag = 1'b0;
              next_cnt = '0;
              next_state = ST_GAP;
            end else begin
              next_op = cmd_in.operation_code_field;
              next_loc = cmd_in.location_field;
              next_cs = 1'b1;
              next_start = 1'b1;
              next_state = ST_SHIFT;
            end
          end
        end
      end
      // frame on the wire
      ST_SHIFT: begin
        if (sh_done) begin
          next_cs = 1'b0;
          next_cnt = '0;
          next_state = ST_GAP;
          // programming ops leave the memory busy: poll for ready
          next_poll = (op == `OP_WRITE) || (op == `OP_WALL) ||
                      (op == `OP_ERASE) || (op == `OP_EALL);
          if (loading) begin
            if (idx == 3'h0) begin
              if (sh_rx == `SIG_BYTE) begin
                next_idx = 3'h1;
              end else begin
                next_loading = 1'b0;
              end
            end else begin
              next_station[{idx_m1, 3'h0} +: 8] = sh_rx;
              if (idx == `ADDR_BYTES) begin
                next_loading = 1'b0;
                next_status.address_loaded_flag = 1'b1;
                next_status.reload_done_flag = reload;
              end else begin
                next_idx = 3'(idx + 3'h1);
              end
            end
          end else if (op == `OP_READ) begin
            next_data = sh_rx;
          end
        end
      end
      // chip select low between frames
      ST_GAP: begin
        next_cnt = CW'(cnt + 1'b1);
        if (cnt == CW'(`CS_GAP_CYC - 1)) begin
          next_cnt = '0;
          if (poll) begin
            next_cs = 1'b1;
            next_state = ST_POLL;
          end else if (loading) begin
            next_op = `OP_RELOAD;
            next_loc = {4'h0, idx};
            next_cs = 1'b1;
            next_start = 1'b1;
            next_state = ST_SHIFT;
          end else begin
            next_reload = 1'b0;
            next_status.operation_busy_flag = 1'b0;
            next_state = ST_IDLE;
          end
        end
      end
      // data pin high means the memory finished programming
      ST_POLL: begin
        next_cnt = CW'(cnt + 1'b1);
        if ((cnt >= CW'(`POLL_SETTLE_CYC)) && din_s) begin
          next_poll = 1'b0;
          next_cs = 1'b0;
          next_status.operation_busy_flag = 1'b0;
          next_state = ST_IDLE;
        end else if (cnt == CW'(TIMEOUT_CYC - 1)) begin
          next_poll = 1'b0;
          next_cs = 1'b0;
          next_status.response_timeout_flag = 1'b1;
          next_status.operation_busy_flag = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // soft reset restarts the boot load; address is kept until reloaded
    if (soft_rst) begin
      next_state = ST_GAP;
      next_cnt = '0;
      next_loading = 1'b1;
      next_reload = 1'b0;
      next_poll = 1'b0;
      next_idx = 3'h0;
      next_cs = 1'b0;
      next_start = 1'b0;
      next_status = '{1'b1, 1'b0, 1'b0, 1'b0};
    end
  end

  // --------------------------------------------------------------
  // sequencer registers; reset starts the boot load with busy high
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_GAP;
      cnt <= '0;
      loading <= 1'b1;
      reload <= 1'b0;
      poll <= 1'b0;
      idx <= 3'h0;
      op <= `OP_READ;
      loc <= 7'h00;
      cs <= 1'b0;
      start <= 1'b0;
      station <= 48'h000000000000;
      memory_command_reg <= '0;
      status <= '{1'b1, 1'b0, 1'b0, 1'b0};
      memory_data_reg <= 8'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      loading <= next_loading;
      reload <= next_reload;
      poll <= next_poll;
      idx <= next_idx;
      op <= next_op;
      loc <= next_loc;
      cs <= next_cs;
      start <= next_start;
      station <= next_station;
      memory_command_reg <= next_cmd;
      status <= next_status;
      memory_data_reg <= next_data;
    end
  end

  assign station_address_low = station[31:0];
  assign station_address_high = station[47:32];

  // --------------------------------------------------------------
  // leaves
  // --------------------------------------------------------------
  bit_sync #(
    .W(1)
  ) u_din_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .d(serial_data_in),
    .q(din_s)
  );

  serial_shifter #(
    .HALF_CYC(HALF_CYC)
  ) u_shifter (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(start),
    .nbits(nbits),
    .drive(drive),
    .tx(tx),
    .done(sh_done),
    .rx(sh_rx),
    .sdi(din_s),
    .sclk(sh_sclk),
    .sdo(sh_sdo),
    .sdo_oe(sh_oe)
  );

  // --------------------------------------------------------------
  // pin mux: disabled interface reuses pins as plain outputs
  // --------------------------------------------------------------
  logic next_pin_cs, next_pin_clk, next_pin_do, next_pin_oe;

  always_comb begin
    if (iface_disable) begin
      next_pin_cs = 1'b0;
      next_pin_clk = pin_mon_sel ? mii_mon[0] : gp_out[0];
      next_pin_do = pin_mon_sel ? mii_mon[1] : gp_out[1];
      next_pin_oe = 1'b1;
    end else begin
      next_pin_cs = cs;
      next_pin_clk = sh_sclk;
      next_pin_do = sh_sdo;
      next_pin_oe = sh_oe;
    end
  end

  // one register stage keeps the pins glitch free
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serial_chip_select <= 1'b0;
      serial_clock_pin <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      serial_chip_select <= next_pin_cs;
      serial_clock_pin <= next_pin_clk;
      serial_data_out <= next_pin_do;
      serial_data_oe <= next_pin_oe;
    end
  end

endmodule : e2p_ctrl
`default_nettype wire

// ===== verification/e2p_ctrl_properties.sv
/*
  port checker for the serial memory controller.
  assumes it is bound to every e2p_ctrl instance.
*/
`timescale 1ns/1ns
`default_nettype none
module e2p_ctrl_checker
  import e2p_pkg::*;
#(
  parameter int TIMEOUT_CYC = 2000,
  parameter int HALF_CYC = 4
) (
  // clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic soft_rst,
  // host side
  input wire logic cmd_write,
  input wire cmd_t cmd_in,
  input wire logic cmd_busy_set,
  input wire cmd_t memory_command_reg,
  input wire flags_t status,
  input wire logic [31:0] station_address_low,
  // pin configuration and pins
  input wire logic iface_disable,
  input wire logic pin_mon_sel,
  input wire logic [1:0] gp_out,
  input wire logic [1:0] mii_mon,
  input wire logic serial_chip_select,
  input wire logic serial_clock_pin,
  input wire logic serial_data_out,
  input wire logic serial_data_oe
);
  // ------------
  // helper counters
  // ------------
  logic busy; // short alias
  logic cs_q; // chip select one clock ago
  logic ck_q; // serial clock one clock ago
  logic [4:0] edges; // serial clock rises in this select
  logic [7:0] high_len; // clocks the serial clock has stood high
  logic [31:0] busy_len; // clocks busy has stood high
  assign busy = status.operation_busy_flag;
  // all counters restart with reset so no stale count survives it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cs_q <= 1'b0;
      ck_q <= 1'b0;
      edges <= 5'h00;
      high_len <= 8'h00;
      busy_len <= 32'h0;
    end else begin
      cs_q <= serial_chip_select;
      ck_q <= serial_clock_pin;
      edges <= (serial_chip_select && !cs_q) ? 5'h00 : edges + 5'(serial_clock_pin && !ck_q);
      high_len <= serial_clock_pin ? high_len + 8'h01 : 8'h00;
      busy_len <= busy ? busy_len + 32'h1 : 32'h0;
    end
  end
  // ------------
  // properties
  // ------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_cmd_start: assert property (cmd_write && cmd_busy_set && !busy && !soft_rst
    |=> busy && memory_command_reg == $past(cmd_in)) else $error("command not taken");
  chk_cmd_refused: assert property (cmd_write && busy && !soft_rst
    |=> $stable(memory_command_reg)) else $error("command taken while busy");
  chk_busy_done: assert property ($fell(busy) |=> !serial_chip_select)
    else $error("busy cleared mid frame");
  chk_soft_restart: assert property (soft_rst |=> busy && status[2:0] == 3'h0)
    else $error("soft reset did not restart load");
  chk_frame_bits: assert property ($fell(serial_chip_select) && !iface_disable
    |-> edges inside {5'd0, 5'd10, 5'd18}) else $error("frame length wrong");
  chk_clock_half: assert property ($fell(serial_clock_pin) && !iface_disable && $past(!iface_disable)
    |-> high_len == 8'(HALF_CYC)) else $error("serial clock half period wrong");
  chk_clock_idle: assert property (!serial_chip_select && $past(!serial_chip_select) && !iface_disable
    && $past(!iface_disable) |-> !serial_clock_pin) else $error("serial clock moves while idle");
  chk_timeout_wait: assert property ($rose(status.response_timeout_flag)
    |-> busy_len >= 32'(TIMEOUT_CYC)) else $error("timeout too early");
  chk_pin_reuse: assert property (iface_disable && $past(iface_disable) |-> serial_data_oe
    && {serial_data_out, serial_clock_pin} == $past(pin_mon_sel ? mii_mon : gp_out))
    else $error("reused pins wrong");
  chk_load_busy: assert property ($rose(status.address_loaded_flag) |-> $past(busy))
    else $error("loaded flag outside a load");
  chk_addr_busy: assert property ($changed(station_address_low) |-> $past(busy))
    else $error("station address moved while idle");
endmodule : e2p_ctrl_checker
bind e2p_ctrl e2p_ctrl_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .HALF_CYC(HALF_CYC)) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .soft_rst(soft_rst), .cmd_write(cmd_write), .cmd_in(cmd_in),
  .cmd_busy_set(cmd_busy_set), .memory_command_reg(memory_command_reg), .status(status),
  .station_address_low(station_address_low), .iface_disable(iface_disable), .pin_mon_sel(pin_mon_sel),
  .gp_out(gp_out), .mii_mon(mii_mon), .serial_chip_select(serial_chip_select),
  .serial_clock_pin(serial_clock_pin), .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe));
`default_nettype wire

// ===== verification/e2p_mem_model.sv
/*
  behavioural three-wire serial memory, 128 bytes.
  assumes a frame of start, opcode, location, data, MSB first.
*/
`timescale 1ns/1ns
`default_nettype none
module e2p_mem_model (
  // pins from the controller
  input wire logic cs,
  input wire logic sclk,
  input wire logic di,
  // data back to the controller
  output logic dq,
  output logic oe
);
  logic [7:0] mem [128]; // contents, preset by the bench
  logic wen = 1'b0; // write-protected at power-up
  logic dead = 1'b0; // bench sets it to never report ready
  logic prog = 1'b0; // last frame tried to program
  logic [4:0] n = 5'h00; // bits seen in this frame
  logic [17:0] sh = 18'h0;
  logic [1:0] op = 2'h0;
  logic [6:0] loc = 7'h00;
  initial begin
    dq = 1'b0;
    oe = 1'b0;
  end
  // select after a programming frame is a ready poll, answered once
  always @(posedge cs) begin
    n = 5'h00;
    oe = prog;
    dq = ~dead;
    prog = 1'b0;
  end
  // deselect releases the line
  always @(negedge cs) oe = 1'b0;
  // bits enter on the rising clock
  always @(posedge sclk) if (cs) begin
    sh = {sh[16:0], di};
    n = n + 5'h01;
    if (n == 5'd10) begin
      op = sh[8:7];
      loc = sh[6:0];
      prog = op == 2'h3 || (op == 2'h0 && loc[6:5] == 2'h2);
      if (op == 2'h3 && wen) mem[loc] = 8'hff;
      if (op == 2'h0 && loc[6:5] == 2'h2 && wen) for (int i = 0; i < 128; i++) mem[i] = 8'hff;
      if (op == 2'h0 && loc[6:5] == 2'h3) wen = 1'b1;
      if (op == 2'h0 && loc[6:5] == 2'h0) wen = 1'b0;
    end
    if (n == 5'd18 && (op == 2'h1 || (op == 2'h0 && loc[6:5] == 2'h1))) begin
      prog = 1'b1;
      if (wen && op == 2'h1) mem[loc] = sh[7:0];
      if (wen && op == 2'h0) for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
    end
  end
  // read data leaves on the falling clock after the location
  always @(negedge sclk) if (cs && op == 2'h2 && n >= 5'd10 && n < 5'd18) begin
    oe = 1'b1;
    dq = mem[loc][5'd17 - n];
  end
endmodule : e2p_mem_model
`default_nettype wire

// ===== verification/serial_eeprom_controller_bench.sv
/*
  bench for the serial memory controller with a memory model.
  assumes e2p_cfg.svh is on the include path.
*/
`timescale 1ns/1ns
`default_nettype none
`include "e2p_cfg.svh"
module serial_eeprom_controller_bench
  import e2p_pkg::*;
;
  localparam int HC = 10; // 80 ns serial clock
  logic clk_sys, sys_rst = 1, soft_rst = 0, cmd_write = 0, busy_set = 1, data_write = 0;
  logic iface_disable = 0, pin_mon_sel = 0, sdo, oe, cs, sclk, m_dq, m_oe, last = 0, sdi;
  logic [1:0] gp_out = 0, mii_mon = 0;
  logic [7:0] data_in = 0, mreg;
  logic [31:0] sal;
  logic [15:0] sah;
  cmd_t cmd_in = 0, creg;
  flags_t st;
  int err_total = 0, compares = 0;
  // undriven line shows the inverse of its last level
  assign sdi = oe ? sdo : (m_oe ? m_dq : ~last);
  always @(posedge clk_sys) last <= sdi;
  initial begin
    clk_sys = 0;
    forever #2 clk_sys = ~clk_sys;
  end
  e2p_ctrl #(.TIMEOUT_CYC(2000), .HALF_CYC(HC)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .cmd_write(cmd_write), .cmd_in(cmd_in), .cmd_busy_set(busy_set),
    .data_write(data_write), .data_in(data_in), .memory_command_reg(creg), .status(st),
    .memory_data_reg(mreg), .station_address_low(sal), .station_address_high(sah),
    .iface_disable(iface_disable), .pin_mon_sel(pin_mon_sel), .gp_out(gp_out), .mii_mon(mii_mon),
    .serial_chip_select(cs), .serial_clock_pin(sclk), .serial_data_out(sdo), .serial_data_oe(oe),
    .serial_data_in(sdi));
  e2p_mem_model i_mem (.cs(cs), .sclk(sclk), .di(sdi), .dq(m_dq), .oe(m_oe));
  // ------------
  // tasks
  // ------------
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bounded wait for busy to clear
  task automatic idle();
    int k;
    k = 0;
    while (st.operation_busy_flag !== 1'b0 && k < 20000) begin
      @(posedge clk_sys); #1;
      k++;
    end
    chk(k < 20000, 1);
  endtask : idle
  task automatic cmd(input logic [2:0] op, input logic [6:0] loc);
    @(posedge clk_sys); #1;
    cmd_in = {op, loc};
    cmd_write = 1;
    @(posedge clk_sys); #1;
    cmd_write = 0;
    idle();
  endtask : cmd
  task automatic wdat(input logic [7:0] d);
    @(posedge clk_sys); #1;
    data_in = d;
    data_write = 1;
    @(posedge clk_sys); #1;
    data_write = 0;
  endtask : wdat
  task automatic rd(input logic [6:0] loc, input logic [7:0] e);
    cmd(`OP_READ, loc);
    chk(mreg, e);
  endtask : rd
  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #400000;
    err_total++;
    close_out();
  end
  // ------------
  // tests
  // ------------
  initial begin
    i_mem.mem[0] = 8'ha5;
    for (int i = 1; i < 7; i++) i_mem.mem[i] = 8'(i * 17);
    i_mem.mem[127] = 8'hc3;
    repeat (10) @(posedge clk_sys);
    #1;
    sys_rst = 0;
    idle();
    chk(st, 4'h2);
    chk({sah, sal}, 48'h665544332211);
    rd(7'h7f, 8'hc3);
    $display("test boot done");
    wdat(8'h3c);
    cmd(`OP_WRITE, 7'h05);
    rd(7'h05, 8'h55);
    cmd(`OP_WEN, 0);
    wdat(8'h3c);
    cmd(`OP_WRITE, 7'h05);
    rd(7'h05, 8'h3c);
    cmd(`OP_ERASE, 7'h05);
    rd(7'h05, 8'hff);
    wdat(8'h5a);
    cmd(`OP_WALL, 0);
    rd(7'h00, 8'h5a);
    rd(7'h7f, 8'h5a);
    cmd(`OP_EALL, 0);
    rd(7'h40, 8'hff);
    chk(st, 4'h2);
    $display("test ops done");
    cmd(`OP_RELOAD, 0);
    chk(st, 4'h0);
    chk({sah, sal}, 48'h665544332211);
    wdat(8'ha5);
    cmd(`OP_WRITE, 7'h00);
    wdat(8'h77);
    cmd(`OP_WRITE, 7'h01);
    cmd(`OP_WDIS, 0);
    wdat(8'h00);
    cmd(`OP_WRITE, 7'h02);
    rd(7'h02, 8'hff);
    cmd(`OP_RELOAD, 0);
    chk(st, 4'h3);
    chk({sah, sal}, 48'hffffffffff77);
    $display("test reload done");
    i_mem.dead = 1;
    cmd(`OP_WEN, 0);
    cmd(`OP_ERASE, 7'h03);
    chk(st, 4'h7);
    i_mem.dead = 0;
    @(posedge clk_sys); #1;
    soft_rst = 1;
    @(posedge clk_sys); #1;
    soft_rst = 0;
    chk(st.operation_busy_flag, 1);
    idle();
    chk(st, 4'h2);
    $display("test timeout and soft reset done");
    @(posedge clk_sys); #1;
    cmd_in = {`OP_READ, 7'h01};
    cmd_write = 1;
    @(posedge clk_sys); #1;
    cmd_in = {`OP_WRITE, 7'h02};
    data_write = 1;
    @(posedge clk_sys); #1;
    cmd_write = 0;
    data_write = 0;
    idle();
    chk(mreg, 8'h77);
    chk(creg, {`OP_READ, 7'h01});
    iface_disable = 1;
    gp_out = 2'h2;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({cs, sdo, sclk, oe}, 4'h5);
    pin_mon_sel = 1;
    mii_mon = 2'h1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({sdo, sclk, oe}, 3'h3);
    gp_out = 0;
    mii_mon = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    iface_disable = 0;
    busy_set = 0;
    cmd(`OP_ERASE, 7'h01);
    chk({st, creg}, {4'h2, `OP_ERASE, 7'h01});
    busy_set = 1;
    rd(7'h01, 8'h77);
    $display("test refuse and pins done");
    close_out();
  end
endmodule : serial_eeprom_controller_bench
`default_nettype wire
